// *** src/pmml_defines.svh ***
// Offsets, reset values and decode limits for the program memory map and lock block
`ifndef PMML_DEFINES_SVH
`define PMML_DEFINES_SVH
`define OFS_DPTR0_LO      8'h82
`define OFS_DPTR0_HI      8'h83
`define OFS_DPTR1_LO      8'h84
`define OFS_DPTR1_HI      8'h85
`define OFS_PTR_SELECT    8'h86
`define OFS_PORT2_LATCH   8'hA0
`define OFS_SIZE_LIMIT    8'hC2
`define OFS_LOCK_STATUS   8'hE6
`define RST_SIZE_LIMIT    3'h5
`define RST_PORT2_LATCH   8'hFF
`define SIZE_LIMIT_HI     5'h1E
`define PTR_SELECT_HI     7'h02
`define TOP_1K            16'h03FF
`define TOP_2K            16'h07FF
`define TOP_4K            16'h0FFF
`define TOP_8K            16'h1FFF
`define TOP_16K           16'h3FFF
`define SEC_LOCK_ADDR     16'h0040
`define ERASED_BYTE       8'hFF
`define VECTOR_TOP        16'h007F
`endif

// *** src/pmml_pkg.sv ***
// Types shared by the program memory map and lock block
package pmml_pkg;
    typedef enum logic [1:0] {
        KIND_FETCH     = 2'h0,
        KIND_CODE_READ = 2'h1,
        KIND_DATA_RI   = 2'h2,
        KIND_DATA_PTR  = 2'h3
    } req_kind_e;
    typedef enum logic [2:0] {
        BUS_IDLE   = 3'h0,
        BUS_ADDR   = 3'h1,
        BUS_STROBE = 3'h3,
        BUS_WAIT   = 3'h2,
        BUS_DATA   = 3'h6
    } bus_state_e;
    typedef enum logic [1:0] {
        MODE_IAP      = 2'h0,
        MODE_LOADER   = 2'h1,
        MODE_PARALLEL = 2'h2
    } prog_mode_e;
endpackage

// *** src/program_memory_map_lock.sv ***
// Program memory decode, external bus strobes, verify encryption and lock levels
// Contract
// - On-chip code is one region from 0000h to 3FFFh.
// - Fetches above the selected limit run over ports 0 and 2.
// - Limit codes 000..101 give none, 03FF, 07FF, 0FFF, 1FFF, 3FFF.
// - Reset selects the full 3FFFh internal space.
// - Limit writes only land while timed access is open.
// - A new limit applies from the very next fetch.
// - Bus cycles put low address/data on port 0, high address on port 2.
// - Force pin low sends every fetch off-chip, overriding the limit but not the level 4 fault.
// - Program strobe goes low during external program fetches.
// - Register-indirect data moves use working register plus port 2 latch.
// - Pointer data moves use one of two pointers chosen by select bit 0.
// - Classic bus fetch takes four clocks, core stalled for three.
// - Page mode 1 never stalls; all other modes stall.
// - Reset and vectors sit in the lowest 128 internal bytes.
// - Internal code is two 8k banks, lower and upper.
// - Once encryption is programmed, verify bytes are XNOR with an array byte.
// - Level 2 blocks external table reads, latches force pin, stops programming.
// - Level 3 also refuses verify and external-code reads of internal SRAM.
// - Level 4 also forbids any external execution.
// - Locks do not restrict in-application access, only loader and parallel.
// - Lock bits only tighten; only mass erase restores them.
// - Lock bits read at security address 40h on bits 5..3.
//
// Our own choices: the placing of the registers and the plain strobed port.
`include "pmml_defines.svh"

module program_memory_map_lock import pmml_pkg::*; (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        timed_access_open,
    input  wire logic        req_valid,
    input  wire req_kind_e   req_kind,
    input  wire logic        req_write,
    input  wire logic [15:0] req_addr,
    input  wire logic [7:0]  req_ri,
    input  wire logic [7:0]  req_wdata,
    input  wire logic        req_from_ext,
    input  wire logic        req_sram_hit,
    input  wire logic        page_mode_one,
    output logic             resp_valid,
    output logic      [7:0]  resp_data,
    output logic             resp_denied,
    output logic             fetch_fault,
    output logic             core_stall,
    output logic             flash_rd,
    output logic             flash_upper_bank,
    output logic      [12:0] flash_addr,
    input  wire logic [7:0]  flash_rdata,
    input  wire logic        bank_swap,
    input  wire logic        external_fetch_force_n,
    input  wire logic [7:0]  port0_in,
    output logic      [7:0]  port0_out,
    output logic             port0_oe,
    output logic      [7:0]  port2_out,
    output logic             port2_oe,
    output logic             addr_latch_en,
    output logic             program_strobe_n,
    output logic             rd_n,
    output logic             wr_n,
    input  wire prog_mode_e  prog_mode,
    input  wire logic        prog_write_req,
    output logic             prog_refused,
    input  wire logic        verify_req,
    input  wire logic        verify_security,
    input  wire logic [15:0] verify_addr,
    output logic             verify_valid,
    output logic             verify_refused,
    output logic      [7:0]  verify_data,
    input  wire logic [2:0]  lock_restore,
    input  wire logic        lock_prog,
    input  wire logic [2:0]  lock_prog_clear,
    input  wire logic        mass_erase,
    input  wire logic        enc_wr,
    input  wire logic [5:0]  enc_addr,
    input  wire logic [7:0]  enc_wdata,
    output logic      [2:0]  lock_state
);
    logic [2:0]  limit;
    logic        ptr_sel;
    logic [7:0]  dp_lo [2];
    logic [7:0]  dp_hi [2];
    logic [7:0]  p2_latch;
    logic        ea_meta;
    logic        ea_sync;
    logic        ea_latched;
    logic [7:0]  p0_meta;
    logic [7:0]  p0_sync;
    logic [7:0]  enc_mem [64];
    logic [63:0] enc_prog;
    logic        enc_active;
    bus_state_e  state;
    logic        bus_prog;
    logic        bus_wr;
    logic        bus_page;
    logic [7:0]  bus_wdata;
    logic        pend_flash;
    logic        pend_deny;
    logic        pend_fault;
    logic        pend_sram;
    logic        ver_pend;
    logic [5:0]  ver_key;
    logic [2:0]  level;
    logic        ea_eff;
    logic [15:0] eff_addr;
    logic        code_int;
    logic        go_flash;
    logic        go_bus;
    logic        go_deny;
    logic        go_fault;
    logic        go_sram;

    function automatic logic [15:0] limit_top(input logic [2:0] c);
        unique case (c)
            3'h1: limit_top = `TOP_1K;
            3'h2: limit_top = `TOP_2K;
            3'h3: limit_top = `TOP_4K;
            3'h4: limit_top = `TOP_8K;
            default: limit_top = `TOP_16K;
        endcase
    endfunction

    // single region from zero; vectors at its base
    function automatic logic is_internal(input logic [15:0] a, input logic [2:0] c,
                                         input logic ea_n);
        is_internal = ea_n && (c != 3'h0) && (a <= limit_top(c));
    endfunction

    function automatic logic [2:0] lock_level(input logic [2:0] lb);
        if (!lb[2]) begin
            lock_level = 3'h4;
        end else if (!lb[1]) begin
            lock_level = 3'h3;
        end else if (!lb[0]) begin
            lock_level = 3'h2;
        end else begin
            lock_level = 3'h1;
        end
    endfunction

    assign level = lock_level(lock_state);

    // Force pin and port 0 come from pins: two flops before use
    always_ff @(posedge clk) begin
        ea_meta <= external_fetch_force_n;
        ea_sync <= ea_meta;
        p0_meta <= port0_in;
        p0_sync <= p0_meta;
    end

    // force pin caught while reset is held
    always_ff @(posedge clk) begin
        if (rst) begin
            ea_latched <= ea_sync;
        end
    end

    // force pin, frozen from reset once locked
    assign ea_eff = (level >= 3'h2) ? ea_latched : ea_sync;

    // lock bits only clear; mass erase restores
    always_ff @(posedge clk) begin
        if (rst) begin
            lock_state <= lock_restore;
        end else if (mass_erase) begin
            lock_state <= 3'h7;
        end else if (lock_prog) begin
            lock_state <= lock_state & ~lock_prog_clear;
        end
    end

    // The array is nonvolatile: reset leaves it, only mass erase clears it
    always_ff @(posedge clk) begin
        if (mass_erase) begin
            for (int i = 0; i < 64; i++) begin
                enc_mem[i] <= `ERASED_BYTE;
            end
        end else if (enc_wr) begin
            enc_mem[enc_addr] <= enc_wdata;
        end
    end

    for (genvar g = 0; g < 64; g++) begin : g_enc
        assign enc_prog[g] = (enc_mem[g] != `ERASED_BYTE);
    end
    assign enc_active = |enc_prog;

    // timed access gate; reserved codes dropped; full space
    always_ff @(posedge clk) begin
        if (rst) begin
            limit <= `RST_SIZE_LIMIT;
        end else if (reg_wr && reg_addr == `OFS_SIZE_LIMIT && timed_access_open
                     && reg_wdata[2:1] != 2'h3) begin
            limit <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ptr_sel  <= 1'b0;
            p2_latch <= `RST_PORT2_LATCH;
            dp_lo    <= '{8'h00, 8'h00};
            dp_hi    <= '{8'h00, 8'h00};
        end else if (reg_wr) begin
            unique case (reg_addr)
                `OFS_PTR_SELECT:  ptr_sel  <= reg_wdata[0];
                `OFS_PORT2_LATCH: p2_latch <= reg_wdata;
                `OFS_DPTR0_LO:    dp_lo[0] <= reg_wdata;
                `OFS_DPTR0_HI:    dp_hi[0] <= reg_wdata;
                `OFS_DPTR1_LO:    dp_lo[1] <= reg_wdata;
                `OFS_DPTR1_HI:    dp_hi[1] <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !reg_rd) begin
            reg_rdata <= 8'h00;
        end else begin
            unique case (reg_addr)
                `OFS_SIZE_LIMIT:  reg_rdata <= {`SIZE_LIMIT_HI, limit};
                `OFS_PTR_SELECT:  reg_rdata <= {`PTR_SELECT_HI, ptr_sel};
                `OFS_PORT2_LATCH: reg_rdata <= p2_latch;
                `OFS_DPTR0_LO:    reg_rdata <= dp_lo[0];
                `OFS_DPTR0_HI:    reg_rdata <= dp_hi[0];
                `OFS_DPTR1_LO:    reg_rdata <= dp_lo[1];
                `OFS_DPTR1_HI:    reg_rdata <= dp_hi[1];
                `OFS_LOCK_STATUS: reg_rdata <= {2'h0, enc_active, ea_eff, 1'b0, lock_state};
                default:          reg_rdata <= 8'h00;
            endcase
        end
    end

    // Request steering; the core only issues while the bus is idle
    always_comb begin
        go_flash = 1'b0;
        go_bus   = 1'b0;
        go_deny  = 1'b0;
        go_fault = 1'b0;
        go_sram  = 1'b0;
        unique case (req_kind)
            // working register low, port 2 latch high
            KIND_DATA_RI:  eff_addr = {p2_latch, req_ri};
            KIND_DATA_PTR: eff_addr = {dp_hi[ptr_sel], dp_lo[ptr_sel]};
            default:       eff_addr = req_addr;
        endcase
        // decode reads the live limit, so a write steers the next fetch
        code_int = is_internal(req_addr, limit, ea_eff);
        if (req_valid && state == BUS_IDLE) begin
            unique case (req_kind)
                KIND_FETCH: begin
                    // no external execution at level 4
                    if (code_int) begin
                        go_flash = 1'b1;
                    end else if (level == 3'h4) begin
                        go_fault = 1'b1;
                    end else begin
                        go_bus = 1'b1;
                    end
                end
                KIND_CODE_READ: begin
                    // from level 2, external code may not read internal code
                    if (code_int && req_from_ext && level >= 3'h2) begin
                        go_deny = 1'b1;
                    end else if (code_int) begin
                        go_flash = 1'b1;
                    end else begin
                        go_bus = 1'b1;
                    end
                end
                default: begin
                    // from level 3, external code may not read internal SRAM
                    if (req_sram_hit && req_from_ext && !req_write && level >= 3'h3) begin
                        go_deny = 1'b1;
                    end else if (req_sram_hit) begin
                        go_sram = 1'b1;
                    end else begin
                        go_bus = 1'b1;
                    end
                end
            endcase
        end
    end

    // external fetch over ports; pins act as bus; strobes
    always_ff @(posedge clk) begin
        if (rst) begin
            state            <= BUS_IDLE;
            bus_prog         <= 1'b0;
            bus_wr           <= 1'b0;
            bus_page         <= 1'b0;
            bus_wdata        <= 8'h00;
            port0_out        <= 8'h00;
            port0_oe         <= 1'b0;
            port2_out        <= `RST_PORT2_LATCH;
            port2_oe         <= 1'b0;
            addr_latch_en    <= 1'b0;
            program_strobe_n <= 1'b1;
            rd_n             <= 1'b1;
            wr_n             <= 1'b1;
            core_stall       <= 1'b0;
        end else begin
            unique case (state)
                BUS_IDLE: begin
                    port2_out <= p2_latch;
                    port2_oe  <= 1'b1;
                    if (go_bus) begin
                        state         <= BUS_ADDR;
                        bus_prog      <= (req_kind == KIND_FETCH) ||
                                         (req_kind == KIND_CODE_READ);
                        bus_wr        <= req_write && req_kind[1];
                        bus_page      <= page_mode_one;
                        bus_wdata     <= req_wdata;
                        port0_out     <= eff_addr[7:0];
                        port0_oe      <= 1'b1;
                        port2_out     <= eff_addr[15:8];
                        addr_latch_en <= 1'b1;
                        // page mode 1 runs without stalling the core
                        core_stall    <= !page_mode_one;
                    end
                end
                BUS_ADDR: begin
                    state            <= BUS_STROBE;
                    addr_latch_en    <= 1'b0;
                    port0_out        <= bus_wdata;
                    port0_oe         <= bus_wr;
                    program_strobe_n <= !bus_prog;
                    rd_n             <= bus_prog || bus_wr;
                    wr_n             <= !bus_wr;
                end
                BUS_STROBE: begin
                    state <= BUS_WAIT;
                end
                BUS_WAIT: begin
                    // stall covers three of the four bus clocks
                    state            <= BUS_DATA;
                    core_stall       <= 1'b0;
                    program_strobe_n <= 1'b1;
                    rd_n             <= 1'b1;
                    wr_n             <= 1'b1;
                    port0_oe         <= 1'b0;
                end
                BUS_DATA: begin
                    state <= BUS_IDLE;
                end
                default: state <= BUS_IDLE;
            endcase
        end
    end

    // Non-bus answers all take two cycles so back-to-back requests never collide
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_flash <= 1'b0;
            pend_deny  <= 1'b0;
            pend_fault <= 1'b0;
            pend_sram  <= 1'b0;
        end else begin
            pend_flash <= go_flash;
            pend_deny  <= go_deny;
            pend_fault <= go_fault;
            pend_sram  <= go_sram;
        end
    end

    // two 8k banks; bank select swaps which one sits low
    always_ff @(posedge clk) begin
        if (rst) begin
            flash_rd         <= 1'b0;
            flash_addr       <= 13'h0000;
            flash_upper_bank <= 1'b0;
        end else begin
            flash_rd <= go_flash || (verify_req && !verify_security);
            if (verify_req) begin
                flash_addr       <= verify_addr[12:0];
                flash_upper_bank <= verify_addr[13] ^ bank_swap;
            end else begin
                flash_addr       <= req_addr[12:0];
                flash_upper_bank <= req_addr[13] ^ bank_swap;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            resp_valid  <= 1'b0;
            resp_data   <= 8'h00;
            resp_denied <= 1'b0;
            fetch_fault <= 1'b0;
        end else begin
            resp_valid  <= pend_flash || pend_deny || pend_fault || pend_sram ||
                           state == BUS_DATA;
            resp_denied <= pend_deny;
            fetch_fault <= pend_fault;
            if (pend_flash) begin
                resp_data <= flash_rdata;
            end else if (state == BUS_DATA) begin
                resp_data <= p0_sync;
            end else begin
                resp_data <= `ERASED_BYTE;
            end
        end
    end

    // locks bind loader and parallel modes only
    always_ff @(posedge clk) begin
        if (rst) begin
            prog_refused   <= 1'b0;
            verify_valid   <= 1'b0;
            verify_refused <= 1'b0;
            verify_data    <= 8'h00;
            ver_pend       <= 1'b0;
            ver_key        <= 6'h00;
        end else begin
            // loader and parallel programming refused from level 2
            prog_refused <= prog_write_req && prog_mode != MODE_IAP && level >= 3'h2;
            ver_pend     <= verify_req && !verify_security &&
                            !(prog_mode != MODE_IAP && level >= 3'h3);
            // low six address bits choose the key byte
            ver_key      <= verify_addr[5:0];
            verify_valid   <= verify_req || ver_pend;
            verify_refused <= 1'b0;
            if (verify_req && prog_mode != MODE_IAP && level >= 3'h3) begin
                verify_refused <= 1'b1;
                verify_data    <= `ERASED_BYTE;
            end else if (verify_req && verify_security) begin
                // lock bits on data bits 5..3
                verify_data <= (verify_addr == `SEC_LOCK_ADDR) ?
                               {2'h3, lock_state[0], lock_state[1], lock_state[2], 3'h7} :
                               `ERASED_BYTE;
            end else if (verify_req) begin
                verify_valid <= 1'b0;
            end else if (ver_pend) begin
                // XNOR with the key once any key byte is programmed
                verify_data <= enc_active ? ~(flash_rdata ^ enc_mem[ver_key]) : flash_rdata;
            end
        end
    end

    a_limit_after_reset: assert property (@(posedge clk)
        $fell(rst) |-> limit == `RST_SIZE_LIMIT) else $error("limit not full after reset");
    a_reserved_code_ignored: assert property (@(posedge clk) disable iff (rst)
        reg_wr && reg_addr == `OFS_SIZE_LIMIT && reg_wdata[2:1] == 2'h3 |=> $stable(limit))
        else $error("reserved limit code was taken");
    a_untimed_write_blocked: assert property (@(posedge clk) disable iff (rst)
        reg_wr && reg_addr == `OFS_SIZE_LIMIT && !timed_access_open |=> $stable(limit))
        else $error("limit changed without timed access");
    a_force_pin_goes_bus: assert property (@(posedge clk) disable iff (rst)
        req_valid && state == BUS_IDLE && req_kind == KIND_FETCH && !ea_eff && !verify_req
        |=> !flash_rd) else $error("fetch stayed on-chip with force pin low");
    a_bus_stall_three: assert property (@(posedge clk) disable iff (rst)
        state == BUS_IDLE && go_bus && !page_mode_one |=> core_stall [*3] ##1 !core_stall
        ##1 resp_valid) else $error("external fetch stall not three of four");
    a_prog_strobe_fetch: assert property (@(posedge clk) disable iff (rst)
        state == BUS_STROBE && bus_prog |-> !program_strobe_n && rd_n && wr_n)
        else $error("program strobe not low on fetch");
    a_page_one_no_stall: assert property (@(posedge clk) disable iff (rst)
        state != BUS_IDLE && bus_page |-> !core_stall) else $error("stall in page mode 1");
    a_level_four_fault: assert property (@(posedge clk) disable iff (rst)
        go_fault |-> level == 3'h4 ##2 resp_valid && fetch_fault)
        else $error("external execution not faulted");
    a_table_read_denied: assert property (@(posedge clk) disable iff (rst)
        go_deny && req_kind == KIND_CODE_READ |=> ##1 resp_valid && resp_denied)
        else $error("table read from external code not denied");
    a_lock_only_tightens: assert property (@(posedge clk) disable iff (rst)
        !mass_erase |=> (lock_state & ~$past(lock_state)) == 3'h0)
        else $error("lock bit released without erase");

    c_external_fetch: cover property (@(posedge clk) disable iff (rst)
        state == BUS_DATA && bus_prog);
    c_denied_read: cover property (@(posedge clk) disable iff (rst) resp_denied);
    c_encrypted_verify: cover property (@(posedge clk) disable iff (rst)
        ver_pend && enc_active);
endmodule

// *** dv/ext_memory_model.sv ***
// Behavioural external program and data memory on the multiplexed port bus
module ext_memory_model (
    input  wire logic       clk,
    input  wire logic [7:0] port0_out,
    input  wire logic [7:0] port2_out,
    input  wire logic       addr_latch_en,
    input  wire logic       program_strobe_n,
    input  wire logic       rd_n,
    output logic      [7:0] port0_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  last = 8'h00;
    wire         drive = !program_strobe_n || !rd_n;
    always @(posedge clk) begin
        addr <= addr_latch_en ? {port2_out, port0_out} : addr;
        last <= drive ? port0_in : last;
    end
    // answer strobes; a released bus shows the inverse, never stale data
    assign port0_in = drive ? addr[7:0] ^ addr[15:8] ^ 8'hA5 : ~last;
endmodule

// *** dv/testbench.sv ***
// Randomised bench for the program memory map and lock block
`include "pmml_defines.svh"
module testbench import pmml_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, timed_access_open = 0, req_valid = 0;
    logic req_from_ext = 0, prog_write_req = 0, verify_req = 0, verify_security = 0;
    logic lock_prog = 0, mass_erase = 0, enc_wr = 0, external_fetch_force_n = 1;
    logic req_write = 0, req_sram_hit = 0, page_mode_one = 0, bank_swap = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, req_ri = 0, req_wdata = 0, enc_wdata = 0;
    logic [15:0] req_addr = 0, verify_addr = 0, a;
    logic [5:0] enc_addr = 0;
    logic [2:0] lock_prog_clear = 0, lock_restore = 3'h7, lock_state;
    req_kind_e req_kind = KIND_FETCH;
    prog_mode_e prog_mode = MODE_IAP;
    logic [7:0] flash_rdata, port0_in, reg_rdata, resp_data, port0_out, port2_out, verify_data;
    logic [12:0] flash_addr;
    logic resp_valid, resp_denied, fetch_fault, core_stall, flash_rd, flash_upper_bank, ps;
    logic port0_oe, port2_oe, addr_latch_en, program_strobe_n, rd_n, wr_n, prog_refused;
    logic verify_valid, verify_refused;
    int err_count = 0, total_checks = 0, seed = 47, n;
    program_memory_map_lock i_dut (.*);
    ext_memory_model i_mem (.*);
    assign flash_rdata = flash_addr[7:0] ^ 8'h3C;
    initial forever #50 clk = ~clk;
    task automatic chk(string w, logic [7:0] e, g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(logic [7:0] ad, d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {ad, d, 1'h1};
        @(posedge clk);
        reg_wr <= 0;
    endtask
    task automatic rd(logic [7:0] ad, e);
        @(posedge clk);
        {reg_addr, reg_rd} <= {ad, 1'h1};
        @(posedge clk);
        reg_rd <= 0;
        @(negedge clk);
        chk("register", e, reg_rdata);
    endtask
    task automatic pulse(int w, logic [7:0] c);
        @(posedge clk);
        {lock_prog_clear, enc_addr, enc_wdata} <= {c[2:0], c[5:0], ~c};
        {prog_write_req, enc_wr, mass_erase, lock_prog} <= 4'(1 << w);
        @(posedge clk);
        {prog_write_req, enc_wr, mass_erase, lock_prog} <= 4'h0;
        @(negedge clk);
    endtask
    task automatic req(req_kind_e k, logic [15:0] f, logic x);
        @(posedge clk);
        {req_kind, req_addr, req_from_ext, req_valid} <= {k, f, x, 1'h1};
        {req_ri, req_wdata} <= f;
        @(posedge clk);
        req_valid <= 0;
        n = 0;
        ps = 0;
        do begin
            @(negedge clk);
            n++;
            if (program_strobe_n === 1'h0) ps = 1;
        end while (resp_valid !== 1'h1 && n < 20);
    endtask
    task automatic fetch(logic [15:0] f, logic [2:0] l);
        logic in;
        in = external_fetch_force_n && l != 0 && f < (16'h0400 << (l - 1));
        req(KIND_FETCH, f, 0);
        chk("fetch data", in ? f[7:0] ^ 8'h3C : f[7:0] ^ f[15:8] ^ 8'hA5, resp_data);
        chk("fetch cycles", in ? 8'h02 : 8'h05, 8'(n));
        chk("program strobe", 8'(!in), 8'(ps));
    endtask
    task automatic ver(logic s, logic [15:0] f);
        @(posedge clk);
        {verify_security, verify_addr, verify_req} <= {s, f, 1'h1};
        @(posedge clk);
        verify_req <= 0;
        repeat (2) if (verify_valid !== 1'h1) @(negedge clk);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        pulse(1, 8'h00);
        rd(`OFS_SIZE_LIMIT, 8'hF5);
        rd(8'h10, 8'h00);
        wr(`OFS_SIZE_LIMIT, 8'hF3);
        rd(`OFS_SIZE_LIMIT, 8'hF5);
        @(posedge clk) timed_access_open <= 1;
        wr(`OFS_SIZE_LIMIT, 8'hF6);
        rd(`OFS_SIZE_LIMIT, 8'hF5);
        // Limit only changes between fetches, as software would do it
        for (int l = 0; l < 6; l++) begin
            wr(`OFS_SIZE_LIMIT, 8'(l));
            for (int j = 0; j < 6; j++) begin
                a = j > 1 ? 16'($random(seed)) : (16'h0400 << (l - 1)) - 16'(1 - j);
                fetch(a, 3'(l));
            end
        end
        @(posedge clk) external_fetch_force_n <= 0;
        repeat (3) @(posedge clk);
        fetch(16'h0010, 3'h5);
        @(posedge clk) external_fetch_force_n <= 1;
        {bank_swap, page_mode_one} <= 2'h3;
        wr(`OFS_DPTR1_LO, 8'h34);
        wr(`OFS_DPTR1_HI, 8'h92);
        wr(`OFS_PTR_SELECT, 8'h01);
        rd(`OFS_PTR_SELECT, 8'h05);
        fetch(16'h2345, 3'h5);
        chk("upper bank", 8'h00, 8'(flash_upper_bank));
        req(KIND_DATA_PTR, 16'h0000, 0);
        chk("pointer data", 8'h34 ^ 8'h92 ^ 8'hA5, resp_data);
        wr(`OFS_PORT2_LATCH, 8'h61);
        req(KIND_DATA_RI, 16'h5A00, 0);
        chk("indirect data", 8'h5A ^ 8'h61 ^ 8'hA5, resp_data);
        {bank_swap, page_mode_one} <= 2'h0;
        $display("map test done");
        pulse(0, 8'h01);
        req(KIND_CODE_READ, 16'h0200, 1);
        chk("denied", 8'h01, 8'(resp_denied));
        @(posedge clk) prog_mode <= MODE_LOADER;
        pulse(3, 8'h00);
        chk("prog refused", 8'h01, 8'(prog_refused));
        pulse(0, 8'h02);
        req_sram_hit <= 1;
        req(KIND_DATA_PTR, 16'h0000, 1);
        chk("sram denied", 8'h01, 8'(resp_denied));
        req_sram_hit <= 0;
        ver(0, 16'h0123);
        chk("verify refused", 8'h01, 8'(verify_refused));
        @(posedge clk) prog_mode <= MODE_IAP;
        ver(1, `SEC_LOCK_ADDR);
        chk("lock bits", 8'hCF, verify_data);
        pulse(0, 8'h04);
        req(KIND_FETCH, 16'h5000, 0);
        chk("fetch fault", 8'h01, 8'(fetch_fault));
        pulse(1, 8'h00);
        chk("lock state", 8'h07, 8'(lock_state));
        pulse(2, 8'h05);
        ver(0, 16'h2105);
        chk("encrypted", ~(8'h05 ^ 8'h3C ^ 8'hFA), verify_data);
        $display("lock test done");
        print_verdict();
    end
endmodule
